// ### hw/osw_pkg.sv
// Package of register map, field positions and codes for the oscillator switch
package osw_pkg;
   // Register byte addresses
   localparam logic [11:0] OSW_CTRL_ADDR = 12'h000;
   localparam logic [11:0] OSW_KEY_ADDR = 12'h004;
   localparam logic [11:0] OSW_STAT_ADDR = 12'h008;
   localparam logic [11:0] OSW_MASK_ADDR = 12'h00C;
   // Control register field positions
   localparam int CUR_LSB = 12;
   localparam int NEXT_LSB = 8;
   localparam int FREEZE_BIT = 7;
   localparam int PINMAP_BIT = 6;
   localparam int PLLOK_BIT = 5;
   localparam int FAIL_BIT = 3;
   localparam int REQ_BIT = 0;
   // Writable bits of the control register
   localparam logic [15:0] CTRL_WMASK = 16'h07C9;
   // Unlock key pair, written in order to the key register
   localparam logic [15:0] KEY_FIRST = 16'h0046;
   localparam logic [15:0] KEY_SECOND = 16'h0057;
   // Status bits: 0 switch done, 1 switch aborted, 2 clock fail
   localparam int EV_DONE = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_FAIL = 2;
   localparam int EV_N = 3;
   // Source encodings
   typedef enum logic [2:0] {
      SRC_FRC = 3'h0,
      SRC_FRC_PLL = 3'h1,
      SRC_PRI = 3'h2,
      SRC_PRI_PLL = 3'h3,
      SRC_RSVD = 3'h4,
      SRC_LOW_POWER_RC_OSC = 3'h5,
      SRC_FRC_DIV16 = 3'h6,
      SRC_FRC_DIVN = 3'h7
   } osw_src_type;
   // Reset value of the current source
   localparam logic [2:0] CUR_RESET = 3'h0;
endpackage

// ### hw/osw_sync.sv
// Two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/100ps
module osw_sync #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // A zero-width bundle has nothing to carry
   if (WIDTH < 1) begin
      $error("WIDTH out of range");
   end

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ### hw/osw_ctrl.sv
// Oscillator control register with clock switch sequencing, APB slave
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
// How it works
// - The new source field at bits 10 to 8 is writable and loads a strap at power-on.
// - With the freeze bit set and monitor strap bit 0 high, clock settings are locked.
// - Bit 6 drives the pin-map freeze output directly.
// - Bit 5 reads the PLL lock status and cannot be written.
// - Bit 3 is set when the fail-safe monitor reports a clock failure.
// - Writing one to bit 3 acts as a real clock failure and raises the trap.
// - Writing one to bit 0 starts a switch; the bit reads zero once it is done.
// - Bits 15, 11, 4, 2 and 1 read zero and ignore writes.
module osw_ctrl #(
   parameter int SW_WAIT = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] next_source_strap,
   input wire logic switch_monitor_cfg_bit0,
   input wire logic pll_locked,
   input wire logic clock_fail_detect,
   input wire logic osc_ready,
   output logic [2:0] current_source,
   output logic pin_map_freeze,
   output logic config_locked,
   output logic osc_fail_trap,
   output logic irq
);
   import osw_pkg::*;

   // The wait counter is 16 bits wide and needs at least one cycle
   if (SW_WAIT < 1 || SW_WAIT > 65535) begin
      $error("SW_WAIT out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_SETTLE = 3'b100
   } osw_state_type;

   osw_state_type state_q, state_d;
   logic [2:0] cur_q, next_q;
   logic freeze_q, pinmap_q, fail_q, req_q;
   logic [1:0] unlock_q;
   logic [1:0] strap_cnt_q;
   logic [15:0] wait_q;
   logic [EV_N-1:0] stat_q, mask_q, ev;
   logic [31:0] prdata_q;
   logic [3:0] pins_s;
   // Strap counts: the two sync stages hold reset zeros until edge two
   localparam logic [1:0] STRAP_LOAD = 2'd2;
   localparam logic [1:0] STRAP_DONE = 2'd3;
   logic pll_s, fail_s, rdy_s, mon_s;
   logic [2:0] strap_s;

   // Pins come from other clock domains, so synchronise first
   // Bit 0 of the pin bundle carries the monitor strap
   osw_sync #(.WIDTH(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({pll_locked, clock_fail_detect, osc_ready,
                 switch_monitor_cfg_bit0}),
      .sync_out(pins_s)
   );
   osw_sync #(.WIDTH(3)) u_strap (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(next_source_strap),
      .sync_out(strap_s)
   );
   assign pll_s = pins_s[3];
   assign fail_s = pins_s[2];
   assign rdy_s = pins_s[1];
   assign mon_s = pins_s[0];

   // Bus decode; APB answers in the access cycle with no wait states
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_ctrl = paddr == OSW_CTRL_ADDR;
   wire hit_key = paddr == OSW_KEY_ADDR;
   wire hit_stat = paddr == OSW_STAT_ADDR;
   wire hit_mask = paddr == OSW_MASK_ADDR;
   wire mapped = hit_ctrl | hit_key | hit_stat | hit_mask;
   wire [15:0] wd = pwdata[15:0] & CTRL_WMASK;
   wire ctrl_wr = wr & hit_ctrl & (unlock_q == 2'd2);
   wire locked = freeze_q & mon_s;
   wire sel_wr = ctrl_wr & ~locked;
   wire [2:0] tgt = next_q;
   wire bad_tgt = tgt == SRC_RSVD ||
      (cur_q == SRC_PRI_PLL && tgt == SRC_FRC_PLL) ||
      (cur_q == SRC_FRC_PLL && tgt == SRC_PRI_PLL);
   wire sw_fail = ctrl_wr & wd[FAIL_BIT];
   wire done_ev = state_q == ST_SETTLE;
   wire abort_ev = state_q == ST_IDLE & req_q & bad_tgt;

   // Outputs; pready is tied high since every access completes at once
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata = prdata_q;
   assign current_source = cur_q;
   assign pin_map_freeze = pinmap_q;
   assign config_locked = locked;
   assign osc_fail_trap = fail_q;
   // Level interrupt while any unmasked status bit is set
   assign ev = {fail_s | sw_fail, abort_ev, done_ev};
   assign irq = |(stat_q & mask_q);

   // Read mux; layout with zeros in unused bits
   wire [15:0] ctrl_rd;
   assign ctrl_rd[15] = 1'b0;
   assign ctrl_rd[11] = 1'b0;
   assign ctrl_rd[4] = 1'b0;
   assign ctrl_rd[2:1] = 2'b00;
   assign ctrl_rd[CUR_LSB +: 3] = cur_q;
   assign ctrl_rd[NEXT_LSB +: 3] = next_q;
   assign ctrl_rd[FREEZE_BIT] = freeze_q;
   assign ctrl_rd[PINMAP_BIT] = pinmap_q;
   assign ctrl_rd[PLLOK_BIT] = pll_s;
   assign ctrl_rd[FAIL_BIT] = fail_q;
   assign ctrl_rd[REQ_BIT] = req_q;
   wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_rd} :
      hit_stat ? {29'h0000_0000, stat_q} :
      hit_mask ? {29'h0000_0000, mask_q} : 32'h0000_0000;

   // Switch sequencer; a source that never reports ready leaves the
   // request bit high, which is how software sees a stuck switch
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (req_q && !bad_tgt) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (rdy_s && wait_q == 16'h0000) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Wait counter reloads while idle so every switch waits the full time
   wire [15:0] wait_d = (state_q == ST_IDLE) ? 16'(SW_WAIT - 1) :
      (wait_q != 16'h0000) ? wait_q - 16'h0001 : wait_q;

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Wait counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 16'h0000;
      end else begin
         wait_q <= wait_d;
      end
   end

   // Unlock key tracker; any other bus write disarms it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q <= 2'd0;
      end else if (wr) begin
         if (hit_key && pwdata[15:0] == KEY_FIRST) begin
            unlock_q <= 2'd1;
         end else if (hit_key && pwdata[15:0] == KEY_SECOND &&
                      unlock_q == 2'd1) begin
            unlock_q <= 2'd2;
         end else begin
            unlock_q <= 2'd0;
         end
      end
   end

   // Strap counter; the strap is taken only once both stages hold it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_q <= 2'd0;
      end else if (strap_cnt_q != STRAP_DONE) begin
         strap_cnt_q <= strap_cnt_q + 2'd1;
      end
   end

   // strap first, then software while no switch runs
   wire strap_load = strap_cnt_q == STRAP_LOAD;
   wire next_wr = sel_wr & (state_q == ST_IDLE);
   wire [2:0] next_d = strap_load ? strap_s :
      next_wr ? wd[NEXT_LSB +: 3] : next_q;

   // New source register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_q <= CUR_RESET;
      end else begin
         next_q <= next_d;
      end
   end

   // freeze cannot be undone while the lock holds
   wire freeze_d = ctrl_wr ? (wd[FREEZE_BIT] | (freeze_q & locked)) :
      freeze_q;
   // pin-map freeze follows bit 6 of each accepted write
   wire pinmap_d = ctrl_wr ? wd[PINMAP_BIT] : pinmap_q;

   // Freeze and pin-map registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freeze_q <= 1'b0;
         pinmap_q <= 1'b0;
      end else begin
         freeze_q <= freeze_d;
         pinmap_q <= pinmap_d;
      end
   end

   // fail flag; a failure in the clearing cycle keeps it set
   wire fail_set = fail_s | sw_fail;
   wire fail_d = fail_set | (fail_q & ~ctrl_wr);

   // Fail flag register, which doubles as the trap output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_q <= 1'b0;
      end else begin
         fail_q <= fail_d;
      end
   end

   // request and completion; done and abort win over a new request
   wire req_set = sel_wr & wd[REQ_BIT];
   wire req_d = (done_ev | abort_ev) ? 1'b0 : (req_q | req_set);
   // current source kept unless the switch completes
   wire [2:0] cur_d = done_ev ? next_q : cur_q;

   // Request and current source registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= CUR_RESET;
         req_q <= 1'b0;
      end else begin
         cur_q <= cur_d;
         req_q <= req_d;
      end
   end

   // Events win over write-one-clear in the same cycle
   wire [EV_N-1:0] stat_clr = {EV_N{wr & hit_stat}} & pwdata[EV_N-1:0];
   wire [EV_N-1:0] stat_d = (stat_q & ~stat_clr) | ev;
   wire [EV_N-1:0] mask_d = (wr & hit_mask) ? pwdata[EV_N-1:0] : mask_q;

   // Status and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
         mask_q <= '0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

   // Read data is taken in the setup cycle and stands until the next
   // read, so the access cycle needs no wait state
   wire rd_setup = psel & ~penable & ~pwrite;
   wire [31:0] prdata_d = rd_setup ? rd_mux : prdata_q;

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end
endmodule

// ### verif/osw_ctrl_assertions.sv
// Port checker for the oscillator switch control block
`timescale 1ns/100ps
module osw_ctrl_chk
   import osw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic clock_fail_detect,
   input wire logic pin_map_freeze,
   input wire logic osc_fail_trap,
   input wire logic [2:0] current_source
);
   // Access decode; read data was latched in the setup cycle
   wire acc = psel && penable;
   wire rd_c = acc && !pwrite && paddr == OSW_CTRL_ADDR;
   wire wr_c = acc && pwrite && paddr == OSW_CTRL_ADDR;
   wire unmap = paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_cur; rd_c |-> prdata[14:12] == $past(current_source);
   endproperty
   a_cur: assert property (p_cur) else $error("source misread");
   property p_unimp; rd_c |-> (prdata & 32'hFFFF_8816) == 32'h0; endproperty
   a_unimp: assert property (p_unimp) else $error("unused bit set");
   property p_pin; !wr_c |=> $stable(pin_map_freeze); endproperty
   a_pin: assert property (p_pin) else $error("pin map moved");
   property p_pinrd; rd_c |-> prdata[6] == $past(pin_map_freeze); endproperty
   a_pinrd: assert property (p_pinrd) else $error("pin map misread");
   property p_fail; $rose(clock_fail_detect) |-> ##[1:4] osc_fail_trap;
   endproperty
   a_fail: assert property (p_fail) else $error("fail not flagged");
   property p_cfrd; rd_c |-> prdata[3] == $past(osc_fail_trap); endproperty
   a_cfrd: assert property (p_cfrd) else $error("fail misread");
   property p_rsv; current_source != SRC_RSVD; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved source");
   property p_err; acc && unmap |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no slave error");
   // Main scenarios
   cover property ($changed(current_source));
   cover property (acc && unmap);
   cover property ($rose(osc_fail_trap));
endmodule
bind osw_ctrl osw_ctrl_chk osw_ctrl_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr),
   .paddr(paddr), .prdata(prdata), .clock_fail_detect(clock_fail_detect),
   .pin_map_freeze(pin_map_freeze), .osc_fail_trap(osc_fail_trap),
   .current_source(current_source));

// ### verif/osw_ctrl_tb_top.sv
// Self-checking bench for the oscillator switch control block
`timescale 1ns/100ps
module osw_ctrl_tb_top;
   import osw_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, seed = 32'h679f;
   logic pready, pslverr, pmf, cfl, trap, irq, err;
   logic mon = 0, pll = 1, cfd = 0, ordy = 1;
   logic [2:0] cur, strap = 3'h2;
   logic [2:0] tgt[11] = '{2, 3, 1, 0, 1, 3, 4, 5, 6, 7, 0};
   logic [2:0] fin[11] = '{2, 3, 3, 0, 1, 1, 1, 5, 6, 7, 0};
   int mismatches = 0, n_compared = 0, cyc = 0, n;
   typedef struct {logic [31:0] e, m;} osw_note_type;
   osw_note_type q[$];
   osw_ctrl #(.SW_WAIT(2)) osw_ctrl_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .next_source_strap(strap),
      .switch_monitor_cfg_bit0(mon), .pll_locked(pll),
      .clock_fail_detect(cfd), .osc_ready(ordy), .current_source(cur),
      .pin_map_freeze(pmf), .config_locked(cfl), .osc_fail_trap(trap),
      .irq(irq));
   initial forever #4 pclk = ~pclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected control word; freeze bit always clear here
   function automatic logic [31:0] ctl(logic [2:0] c, x, logic p, f);
      return {17'h0, c, 1'b0, x, 1'b0, p, pll, 1'b0, f, 3'h0};
   endfunction
   task automatic check(string nm, logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One APB transfer, then one idle cycle so no signal is set twice
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   // Key pair then control write; unused bits get random junk
   task automatic wctl(logic [15:0] d);
      xfer(1, OSW_KEY_ADDR, {16'h0, KEY_FIRST});
      xfer(1, OSW_KEY_ADDR, {16'h0, KEY_SECOND});
      xfer(1, OSW_CTRL_ADDR, {16'h0, d} | (rnd() & 32'hFFFF_8816));
   endtask
   task automatic rdq(logic [11:0] a, logic [31:0] e, m);
      q.push_back('{e, m});
      xfer(0, a, 0);
   endtask
   // Oldest note is judged against the read data of its access
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && q.size() > 0) begin
         check("read", prdata & q[0].m, q[0].e & q[0].m);
         void'(q.pop_front());
      end
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      rdq(OSW_CTRL_ADDR, ctl(0, strap, 0, 0), '1);
      // Write without the key pair must be dropped
      xfer(1, OSW_CTRL_ADDR, 32'h0040);
      check("pin map", pmf, 0);
      wctl(16'h0040);
      check("pin map", pmf, 1);
      // Walk every code, including refused switches
      foreach (tgt[i]) begin
         wctl({5'h0, tgt[i], 8'h41});
         n = 0;
         do begin
            xfer(0, OSW_CTRL_ADDR, 0);
            n++;
         end while (r[0] !== 1'b0 && n < 40);
         rdq(OSW_CTRL_ADDR, ctl(fin[i], tgt[i], 1, 0), '1);
         check("source", cur, fin[i]);
      end
      // Done and abort events, masked, then abort alone unmasked
      rdq(OSW_STAT_ADDR, 3, 3);
      check("irq", irq, 0);
      xfer(1, OSW_MASK_ADDR, 2);
      check("irq", irq, 1);
      xfer(1, OSW_STAT_ADDR, 3);
      check("irq", irq, 0);
      rdq(OSW_STAT_ADDR, 0, 3);
      // Monitor failure, software clear and software set
      cfd <= 1;
      repeat (3) @(posedge pclk);
      cfd <= 0;
      repeat (4) @(posedge pclk);
      check("trap", trap, 1);
      rdq(OSW_CTRL_ADDR, 8, 8);
      wctl(16'h0040);
      check("trap", trap, 0);
      wctl(16'h0048);
      check("trap", trap, 1);
      rdq(OSW_STAT_ADDR, 4, 4);
      // Freeze with monitor strap high blocks a switch
      mon <= 1;
      wctl(16'h00C0);
      check("locked", cfl, 1);
      wctl(16'h0241);
      repeat (20) @(posedge pclk);
      check("source", cur, 0);
      rdq(OSW_CTRL_ADDR, 32'h0080, 32'h0781);
      // PLL drops out of lock and the status bit follows
      pll <= 0;
      repeat (4) @(posedge pclk);
      rdq(OSW_CTRL_ADDR, 32'h0000, 32'h0020);
      void'(rnd());
      xfer(0, {4'h1, seed[7:2], 2'h0}, 0);
      check("slverr", err, 1);
      check("rdata", r, 0);
      end_of_test();
   end
endmodule
